/* File: verilog/bklrs_pkg.sv */
package bklrs_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [15:0] BKLRS_ADDR_WAKE_STATUS  = 16'hfe00;
    localparam logic [15:0] BKLRS_ADDR_RESET_CAUSE  = 16'hfe01;
    localparam logic [15:0] BKLRS_ADDR_CLEAR_CTRL   = 16'hfe03;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BKLRS_BIT_STOP_WAIT   = 1;
    localparam int BKLRS_BIT_CLEAR_EN    = 7;
    localparam int BKLRS_BIT_POWER_ON    = 7;
    localparam int BKLRS_BIT_PIN         = 6;
    localparam int BKLRS_BIT_WATCHDOG    = 5;
    localparam int BKLRS_BIT_ILL_OPCODE  = 4;
    localparam int BKLRS_BIT_ILL_ADDRESS = 3;
    localparam int BKLRS_BIT_LOW_VOLTAGE = 1;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] BKLRS_RST_RESET_CAUSE = 8'h80;
    localparam logic       BKLRS_RST_CLEAR_EN    = 1'b0;
    localparam logic       BKLRS_RST_STOP_WAIT   = 1'b0;
    localparam logic [7:0] BKLRS_RESET_CAUSE_MASK = 8'hfa;

    // ****************************************
    // Timing counts (oscillator cycles)
    // ****************************************
    localparam logic [12:0] BKLRS_STOP_REC_LONG  = 13'h1000;
    localparam logic [12:0] BKLRS_STOP_REC_SHORT = 13'h0020;

    // ****************************************
    // Power state machine
    // ****************************************
    typedef enum logic [4:0]
    {
        BKLRS_RUN      = 5'b0_0001,
        BKLRS_WAIT     = 5'b0_0010,
        BKLRS_STOP     = 5'b0_0100,
        BKLRS_RECOVER  = 5'b0_1000,
        BKLRS_STACK    = 5'b1_0000
    } bklrs_state_t;

    // Reset sources gathered together
    typedef struct packed
    {
        logic power_on;
        logic pin;
        logic watchdog;
        logic ill_opcode;
        logic ill_address;
        logic low_voltage;
    } bklrs_rst_src_t;

    // Clock gating outputs
    typedef struct packed
    {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic watchdog_run;
    } bklrs_clk_ctl_t;

endpackage

/* File: verilog/bklrs_top.sv */
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps

// Summary of operation
// - All resets equal priority, above interrupts
// - Break request forces software interrupt vector fetch
// - Break without enable blocks flag clears
// - Flag cleared in break stays cleared
// - Two-step clears stay protected in break
// - Wait/stop clear mask bit, halt CPU
// - Wait stops CPU clock, peripherals run
// - Wait wake stacks one cycle later
// - Wait exits on reset/break; break sets flag
// - Watchdog runs in wait unless disabled
// - Stop resets counter, gates clock output
// - Stop exit stacks only after recovery
// - Recovery 4096 cycles, or 32 if short
// - Counter held reset until recovery begins
// - Break in stop sets stop/wait flag
// - Write 0 clears stop/wait flag; reset clears
// - Reading reset cause clears its flags
// - Power-on sets only power-on flag
// - Reset cause bit layout, bits 2,0 zero
// - Illegal address flag only for fetches
// - Clear enable bit 7, resets to 0
// - Latched interrupt keeps precedence until serviced
module bklrs_top
    import bklrs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [7:0]  avs_writedata,
    output logic      [7:0]  avs_readdata,
    output logic             avs_waitrequest,
    // Reset sources, level while a reset is requested
    input  wire logic        rst_power_on,
    input  wire logic        rst_pin,
    input  wire logic        rst_watchdog,
    input  wire logic        rst_ill_opcode,
    input  wire logic        rst_ill_address,
    input  wire logic        rst_ill_addr_fetch,
    input  wire logic        rst_low_voltage,
    // CPU side
    input  wire logic        break_request,
    input  wire logic        wait_exec,
    input  wire logic        stop_exec,
    input  wire logic        irq_pending,
    input  wire logic        irq_serviced,
    input  wire logic        osc_tick,
    input  wire logic        short_stop_recovery_select,
    input  wire logic        watchdog_disable_option,
    // Status-flag clear requests from peripherals
    input  wire logic        flag_clear_req,
    // Outputs
    output logic             sys_reset,
    output logic             force_swi_fetch,
    output logic             clear_int_mask,
    output logic             stack_start,
    output logic             irq_latched,
    output logic             break_mode,
    output logic             flag_clear_allow,
    output logic             cpu_clk_en,
    output logic             clock_generator_output_en,
    output logic             watchdog_run
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Fetch qualifier gets its own flops; no gate sits ahead of the first stage
    logic [8:0] sync1_q;
    logic [8:0] sync2_q;
    logic [8:0] raw_in;
    assign raw_in = {rst_power_on, rst_pin, rst_watchdog, rst_ill_opcode,
                     rst_ill_address, rst_ill_addr_fetch, rst_low_voltage,
                     break_request, irq_pending};

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1_q <= 9'h000;
            sync2_q <= 9'h000;
        end
        else
        begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    bklrs_rst_src_t src;
    logic           brk_s;
    logic           irq_s;
    logic           any_rst;
    assign src     = bklrs_rst_src_t'({sync2_q[8:5], sync2_q[4] & sync2_q[3],
                                       sync2_q[2]});
    assign brk_s   = sync2_q[1];
    assign irq_s   = sync2_q[0];
    assign any_rst = |src;

    // ****************************************
    // Register bus decode
    // ****************************************
    logic rd_cause;
    logic wr_wake;
    logic wr_ctrl;
    logic wait_q;
    assign rd_cause = avs_read & ~wait_q & (avs_address == BKLRS_ADDR_RESET_CAUSE);
    assign wr_wake  = avs_write & ~wait_q & (avs_address == BKLRS_ADDR_WAKE_STATUS);
    assign wr_ctrl  = avs_write & ~wait_q & (avs_address == BKLRS_ADDR_CLEAR_CTRL);

    // One wait state per access, answer on the second edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            wait_q <= 1'b1;
        else if ((avs_read | avs_write) & wait_q)
            wait_q <= 1'b0;
        else
            wait_q <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= ~((avs_read | avs_write) & wait_q);
    end

    // ****************************************
    // Reset cause register
    // ****************************************
    logic [7:0] cause_q;
    logic [7:0] cause_set;
    always_comb
    begin
        cause_set = 8'h00;
        cause_set[BKLRS_BIT_POWER_ON]    = src.power_on;
        cause_set[BKLRS_BIT_PIN]         = src.pin;
        cause_set[BKLRS_BIT_WATCHDOG]    = src.watchdog;
        cause_set[BKLRS_BIT_ILL_OPCODE]  = src.ill_opcode;
        cause_set[BKLRS_BIT_ILL_ADDRESS] = src.ill_address;
        cause_set[BKLRS_BIT_LOW_VOLTAGE] = src.low_voltage;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cause_q <= BKLRS_RST_RESET_CAUSE;
        else if (src.power_on)
            cause_q <= BKLRS_RST_RESET_CAUSE;
        else if (rd_cause)
            cause_q <= cause_set & BKLRS_RESET_CAUSE_MASK;
        else
            cause_q <= (cause_q | cause_set) & BKLRS_RESET_CAUSE_MASK;
    end

    // ****************************************
    // Break status and clear control
    // ****************************************
    logic clear_en_q;
    logic stop_wait_q;
    logic break_q;
    bklrs_state_t state_q;
    logic brk_wake;
    assign brk_wake = brk_s & ((state_q == BKLRS_WAIT) | (state_q == BKLRS_STOP)
                               | (state_q == BKLRS_RECOVER));

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            clear_en_q <= BKLRS_RST_CLEAR_EN;
        else if (wr_ctrl)
            clear_en_q <= avs_writedata[BKLRS_BIT_CLEAR_EN];
    end

    // Set wins over a same-cycle software clear
    always_ff @(posedge clk)
    begin
        if (!rst_n || any_rst)
            stop_wait_q <= BKLRS_RST_STOP_WAIT;
        else if (brk_wake)
            stop_wait_q <= 1'b1;
        else if (wr_wake && !avs_writedata[BKLRS_BIT_STOP_WAIT])
            stop_wait_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || any_rst)
            break_q <= 1'b0;
        else
            break_q <= brk_s;
    end

    // Peripherals keep their own two-step state; the gate applies to the
    // final clearing step only, so a step done before break stays pending
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            flag_clear_allow <= 1'b0;
        else
            flag_clear_allow <= flag_clear_req & (~break_q | clear_en_q);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            avs_readdata <= 8'h00;
        else if (avs_read & wait_q)
        begin
            case (avs_address)
                BKLRS_ADDR_WAKE_STATUS: avs_readdata <= {6'h00, stop_wait_q, 1'b0};
                BKLRS_ADDR_RESET_CAUSE: avs_readdata <= cause_q;
                BKLRS_ADDR_CLEAR_CTRL:  avs_readdata <= {clear_en_q, 7'h00};
                default:                avs_readdata <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Low-power state machine
    // ****************************************
    logic [12:0] rec_cnt_q;
    logic [12:0] rec_target;
    assign rec_target = short_stop_recovery_select ? BKLRS_STOP_REC_SHORT
                                                   : BKLRS_STOP_REC_LONG;

    always_ff @(posedge clk)
    begin
        if (!rst_n || any_rst)
            state_q <= BKLRS_RUN;
        else
        begin
            case (state_q)
                BKLRS_RUN:
                    if (stop_exec)
                        state_q <= BKLRS_STOP;
                    else if (wait_exec)
                        state_q <= BKLRS_WAIT;
                BKLRS_WAIT:
                    if (irq_s | brk_s)
                        state_q <= BKLRS_STACK;
                BKLRS_STOP:
                    if (irq_s | brk_s)
                        state_q <= BKLRS_RECOVER;
                BKLRS_RECOVER:
                    if (osc_tick && rec_cnt_q == rec_target - 13'h0001)
                        state_q <= BKLRS_STACK;
                BKLRS_STACK:
                    state_q <= BKLRS_RUN;
                default:
                    state_q <= BKLRS_RUN;
            endcase
        end
    end

    // Counter counts oscillator ticks, 13 bits covers 4096
    always_ff @(posedge clk)
    begin
        if (!rst_n || state_q != BKLRS_RECOVER)
            rec_cnt_q <= 13'h0000;
        else if (osc_tick)
            rec_cnt_q <= rec_cnt_q + 13'h0001;
    end

    // ****************************************
    // Clock control and CPU strobes
    // ****************************************
    logic low_pwr_d;
    assign low_pwr_d = (state_q == BKLRS_RUN) & (wait_exec | stop_exec);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cpu_clk_en                <= 1'b1;
            clock_generator_output_en <= 1'b1;
            watchdog_run              <= 1'b1;
            clear_int_mask            <= 1'b0;
            stack_start               <= 1'b0;
            sys_reset                 <= 1'b1;
            force_swi_fetch           <= 1'b0;
            break_mode                <= 1'b0;
        end
        else
        begin
            cpu_clk_en <= (state_q == BKLRS_RUN | state_q == BKLRS_STACK)
                          & ~low_pwr_d;
            clock_generator_output_en <= ~(state_q == BKLRS_STOP
                                           | state_q == BKLRS_RECOVER)
                                         & ~(state_q == BKLRS_RUN & stop_exec);
            watchdog_run   <= ~watchdog_disable_option & (state_q != BKLRS_STOP);
            clear_int_mask <= low_pwr_d;
            stack_start    <= (state_q == BKLRS_STACK) & ~any_rst;
            sys_reset      <= any_rst;
            force_swi_fetch <= brk_s & ~break_q & ~any_rst;
            break_mode     <= break_q;
        end
    end

    // ****************************************
    // Interrupt latch
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n || any_rst)
            irq_latched <= 1'b0;
        else if (irq_serviced)
            irq_latched <= 1'b0;
        else if (irq_s && !any_rst)
            irq_latched <= 1'b1;
    end

endmodule

/* File: test/bklrs_props.sv */
`timescale 1ns/1ps
module bklrs_props
    import bklrs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Requests into the block
    input wire logic rst_power_on,
    input wire logic break_request,
    input wire logic wait_exec,
    input wire logic stop_exec,
    input wire logic irq_pending,
    input wire logic flag_clear_req,
    // Block outputs
    input wire logic sys_reset,
    input wire logic force_swi_fetch,
    input wire logic clear_int_mask,
    input wire logic stack_start,
    input wire logic flag_clear_allow,
    input wire logic cpu_clk_en,
    input wire logic clock_generator_output_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ********
    // Sequences
    // ********
    sequence s_lowpower;
        wait_exec || stop_exec;
    endsequence
    sequence s_waiting;
        !cpu_clk_en && clock_generator_output_en;
    endsequence

    a_mask_clear: assert property (s_lowpower |-> ##[1:3] clear_int_mask)
        else $error("mask not cleared");
    a_wait_halts: assert property (wait_exec |-> ##[1:3] s_waiting)
        else $error("wait clocks wrong");
    a_stop_gates: assert property (stop_exec |-> ##[1:3] !clock_generator_output_en)
        else $error("stop clock not gated");
    a_wait_wake: assert property (s_waiting ##0 $rose(irq_pending) |-> ##[1:8] stack_start)
        else $error("no stacking after wake");
    a_swi_break: assert property ($rose(break_request) |-> ##[1:5] force_swi_fetch)
        else $error("no vector fetch on break");
    a_swi_idle: assert property (!break_request[*4] |-> !force_swi_fetch)
        else $error("vector fetch without break");
    a_reset_first: assert property (rst_power_on |-> ##[1:4] sys_reset)
        else $error("reset not raised");
    a_clear_idle: assert property (!flag_clear_req |=> !flag_clear_allow)
        else $error("clear without request");
endmodule

bind bklrs_top bklrs_props i_props (.clk(clk), .rst_n(rst_n), .rst_power_on(rst_power_on),
    .break_request(break_request), .wait_exec(wait_exec), .stop_exec(stop_exec),
    .irq_pending(irq_pending), .flag_clear_req(flag_clear_req), .sys_reset(sys_reset),
    .force_swi_fetch(force_swi_fetch), .clear_int_mask(clear_int_mask),
    .stack_start(stack_start), .flag_clear_allow(flag_clear_allow), .cpu_clk_en(cpu_clk_en),
    .clock_generator_output_en(clock_generator_output_en));

/* File: test/bklrs_cpu_model.sv */
`timescale 1ns/1ps
module bklrs_cpu_model
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Commands from the bench, stacking strobe from the block
    input  wire logic irq_go,
    input  wire logic brk_go,
    input  wire logic stack_start,
    // Toward the block
    output logic      irq_pending,
    output logic      irq_serviced,
    output logic      break_request,
    output logic      osc_tick
);
    // Tick every other cycle, so recovery really depends on the enable
    // Request held until stacking takes it, as a real source would
    always_ff @(posedge clk)
    begin
        irq_pending   <= rst_n && !stack_start && (irq_pending || irq_go);
        irq_serviced  <= rst_n && stack_start;
        break_request <= rst_n && brk_go;
        osc_tick      <= rst_n && !osc_tick;
    end
endmodule

/* File: test/test_bklrs_top.sv */
`timescale 1ns/1ps
module test_bklrs_top;
    import bklrs_pkg::*;
    logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, fetch, short_sel, wd_off;
    logic        wait_exec, stop_exec, irq_pending, irq_serviced, osc_tick, break_request;
    logic        flag_clear_req, irq_go, brk_go, sys_reset, force_swi_fetch, clear_int_mask;
    logic        stack_start, irq_latched, break_mode, flag_clear_allow, cpu_clk_en;
    logic        clock_generator_output_en, watchdog_run;
    logic [15:0] avs_address;
    logic [7:0]  avs_writedata, avs_readdata, q;
    logic [5:0]  src;
    int          bad_count, total_checks, n, i, e;

    bklrs_top i_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rst_power_on(src[5]), .rst_pin(src[4]), .rst_watchdog(src[3]),
        .rst_ill_opcode(src[2]), .rst_ill_address(src[1]), .rst_ill_addr_fetch(fetch),
        .rst_low_voltage(src[0]), .break_request(break_request), .wait_exec(wait_exec),
        .stop_exec(stop_exec), .irq_pending(irq_pending), .irq_serviced(irq_serviced),
        .osc_tick(osc_tick), .short_stop_recovery_select(short_sel),
        .watchdog_disable_option(wd_off), .flag_clear_req(flag_clear_req),
        .sys_reset(sys_reset), .force_swi_fetch(force_swi_fetch),
        .clear_int_mask(clear_int_mask), .stack_start(stack_start),
        .irq_latched(irq_latched), .break_mode(break_mode),
        .flag_clear_allow(flag_clear_allow), .cpu_clk_en(cpu_clk_en),
        .clock_generator_output_en(clock_generator_output_en), .watchdog_run(watchdog_run));

    bklrs_cpu_model i_cpu (.clk(clk), .rst_n(rst_n), .irq_go(irq_go), .brk_go(brk_go),
        .stack_start(stack_start), .irq_pending(irq_pending), .irq_serviced(irq_serviced),
        .break_request(break_request), .osc_tick(osc_tick));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ********
    // Helpers
    // ********
    task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] s);
        total_checks++;
        if (s !== x)
        begin
            bad_count++;
            $display("[ERR] %s exp %h seen %h", nm, x, s);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic guard(input int lim);
        if (n >= lim)
        begin
            bad_count++;
            report_and_stop();
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask

    // Request held until the edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        guard(40);
    endtask

    task automatic rdc(input string nm, input logic [15:0] a, input logic [7:0] x);
        bus(1'b0, a, 8'h00);
        chk(nm, 16'(x), 16'(q));
    endtask

    // 0 wait, 1 stop, 2 interrupt
    task automatic go(input int w);
        @(posedge clk);
        wait_exec <= (w == 0);
        stop_exec <= (w == 1);
        irq_go    <= (w == 2);
        @(posedge clk);
        {wait_exec, stop_exec, irq_go} <= 3'b000;
    endtask

    task automatic clr(input logic x);
        @(posedge clk);
        flag_clear_req <= 1'b1;
        tick(2);
        chk("clear_allow", 16'(x), 16'(flag_clear_allow));
        flag_clear_req <= 1'b0;
    endtask

    task automatic stack_wait();
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (stack_start !== 1'b1 && n < 10000);
        guard(10000);
    endtask

    function automatic logic [7:0] cause(input logic [5:0] v);
        return {v[5:1], 1'b0, v[0], 1'b0};
    endfunction

    // ********
    // Scenarios
    // ********
    initial
    begin
        {rst_n, avs_read, avs_write, fetch, wait_exec, stop_exec} = 6'h00;
        {short_sel, wd_off, flag_clear_req, irq_go, brk_go} = 5'h00;
        src = 6'h00;
        avs_address = 16'h0000;
        avs_writedata = 8'h00;
        void'($urandom(64));
        tick(12);
        rst_n <= 1'b1;
        rdc("cause", BKLRS_ADDR_RESET_CAUSE, BKLRS_RST_RESET_CAUSE);
        rdc("cause", BKLRS_ADDR_RESET_CAUSE, 8'h00);
        rdc("ctrl", BKLRS_ADDR_CLEAR_CTRL, 8'h00);
        rdc("wake", BKLRS_ADDR_WAKE_STATUS, 8'h00);
        rdc("hole", 16'hfe02, 8'h00);
        // Last pass is an illegal address from a data access
        for (i = 0; i < 7; i++)
        begin
            @(posedge clk);
            src   <= (i == 6) ? 6'h02 : 6'h01 << i;
            fetch <= (i != 6);
            tick(5 + $urandom_range(3));
            chk("sys_reset", 16'(i != 6), 16'(sys_reset));
            src <= 6'h00;
            tick(8);
            rdc("cause", BKLRS_ADDR_RESET_CAUSE, cause((i == 6) ? 6'h00 : 6'h01 << i));
        end
        brk_go <= 1'b1;
        tick(8);
        chk("break_mode", 16'h0001, 16'(break_mode));
        clr(1'b0);
        bus(1'b1, BKLRS_ADDR_CLEAR_CTRL, 8'h80 | 8'($urandom_range(127)));
        rdc("ctrl", BKLRS_ADDR_CLEAR_CTRL, 8'h80);
        clr(1'b1);
        bus(1'b1, BKLRS_ADDR_CLEAR_CTRL, 8'($urandom_range(127)));
        rdc("ctrl", BKLRS_ADDR_CLEAR_CTRL, 8'h00);
        brk_go <= 1'b0;
        tick(8);
        chk("break_mode", 16'h0000, 16'(break_mode));
        clr(1'b1);
        go(0);
        tick(4);
        chk("wait_clk", 16'h0001, 16'(clock_generator_output_en && !cpu_clk_en));
        chk("watchdog", 16'h0001, 16'(watchdog_run));
        wd_off <= 1'b1;
        tick(3);
        chk("watchdog", 16'h0000, 16'(watchdog_run));
        wd_off <= 1'b0;
        go(2);
        stack_wait();
        chk("wake", 16'h0001, 16'(n < 10));
        chk("irq_latched", 16'h0001, 16'(irq_latched));
        // Break ends wait, stop, then wait again cleared by reset
        for (i = 0; i < 3; i++)
        begin
            short_sel <= 1'b1;
            go(i & 1);
            tick(3);
            brk_go <= 1'b1;
            tick(100);
            rdc("wake", BKLRS_ADDR_WAKE_STATUS, 8'h02);
            brk_go <= 1'b0;
            tick(6);
            if (i == 2)
            begin
                src <= 6'h10;
                tick(6);
                src <= 6'h00;
                tick(8);
            end
            else
                bus(1'b1, BKLRS_ADDR_WAKE_STATUS, 8'h00);
            rdc("wake", BKLRS_ADDR_WAKE_STATUS, 8'h00);
        end
        // Random dwell in stop: the count must not start early
        for (i = 0; i < 3; i++)
        begin
            short_sel <= (i < 2);
            // Model ticks every other cycle
            e = (i < 2) ? 64 : 8192;
            go(1);
            tick(3 + $urandom_range(20));
            chk("stop_clk", 16'h0000, 16'(clock_generator_output_en));
            go(2);
            stack_wait();
            chk("recover", 16'h0001, 16'(n >= e && n < e + 14));
        end
        report_and_stop();
    end
endmodule
